// *** shared/accel_spi_consts.svh ***
// Purpose: Constants for the serial command decoder.
// Assumes: core_clk at 100 MHz.
// Notes:   Command codes, status bit positions and refresh timing.
`ifndef ACCEL_SPI_CONSTS_SVH
`define ACCEL_SPI_CONSTS_SVH

`define CMD_MEASURE     8'h00
`define CMD_TEMP_RW     8'h08
`define CMD_STATUS_RD   8'h0a
`define CMD_NV_RELOAD   8'h0b
`define CMD_SELFTEST_Z  8'h0e
`define CMD_SELFTEST_Y  8'h0f
`define CMD_ACCEL_Z_RD  8'h10
`define CMD_ACCEL_Y_RD  8'h11

`define STAT_PARITY_BIT 3
`define STAT_TEST_BIT   2
`define STAT_LOCK_BIT   1
`define STAT_PD_BIT     0

`define CMD_BITS        8
`define ACCEL_BITS      11
`define REFRESH_US      150
`define CLK_MHZ         100
`define REFRESH_CYCLES  (`REFRESH_US * `CLK_MHZ)

`endif

// *** shared/accel_spi_pkg.sv ***
// Purpose: Types for the serial command decoder.
// Assumes: Constants come from accel_spi_consts.svh.
// Notes:   Holds only types.
package accel_spi_pkg;

  typedef enum logic [1:0] {
    LINK_CMD    = 2'b00,
    LINK_DATA   = 2'b01,
    LINK_IGNORE = 2'b10
  } link_state_t;

  typedef struct packed {
    logic parity_fault_flag;
    logic analog_test;
    logic lock_closed;
    logic powerdown_flag;
  } sensor_status_flags_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } cmd_word_t;

endpackage

// *** hdl/accel_spi_command_decoder.sv ***
// Purpose: Serial slave that decodes the end-user command set of a two-axis sensor.
// Assumes: The link runs on the master's serial clock, a second domain.
// Notes:   Data registers refresh from the converter unless chip select is low.
// Function
// - Chip select frames; 8-bit command MSB first.
// - Decode measure, temperature and status codes.
// - Decode reload, Z and Y self-test codes.
// - Decode Z and Y acceleration read codes.
// - Measure mode after reset.
// - Measure command ends any running self-test.
// - Temperature read leaves measurement undisturbed.
// - Temperature refresh every 150 us, paused selected.
// - Status bit 3 shows parity fault.
// - Status bit 2 shows analog test mode.
// - Status bit 1 shows lock closed.
// - Status bit 0 shows power-down.
// - Reload copies nonvolatile data to output register.
// - Z self-test drives pump and Z deflection.
// - Y self-test drives pump and Y deflection.
// - Z read shifts 11 bits MSB first.
// - Y read shifts 11 bits MSB first.
// - Acceleration refresh every 150 us, paused selected.
`include "accel_spi_consts.svh"

module accel_spi_command_decoder #(
  parameter int TEMP_BITS    = 8,
  parameter int NV_BITS      = 16,
  parameter int REFRESH_CYC  = `REFRESH_CYCLES
) (
  // System
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    clk_en,
  // Serial link
  input  wire logic                    spi_sck,
  input  wire logic                    chip_select_n,
  input  wire logic                    spi_mosi,
  output logic                         spi_miso_o,
  output logic                         spi_miso_oe_n,
  // Converter and chip state
  input  wire logic [`ACCEL_BITS-1:0]  conv_accel_z,
  input  wire logic [`ACCEL_BITS-1:0]  conv_accel_y,
  input  wire logic [TEMP_BITS-1:0]    conv_temp,
  input  wire accel_spi_pkg::sensor_status_flags_t chip_status,
  input  wire logic [NV_BITS-1:0]      nv_data,
  // Analog controls
  output logic                         charge_pump_en,
  output logic                         selftest_z_en,
  output logic                         selftest_y_en,
  output logic [NV_BITS-1:0]           mem_out_q
);

  // ----------------------------------------------------------------------
  // Data registers in the core domain
  // ----------------------------------------------------------------------
  // Chip select is synchronised before the refresh timer reads it.
  // At the default count one interval is 150 us of core clock.
  logic                   cs_sync;
  logic [13:0]            refresh_cnt_q;
  logic [`ACCEL_BITS-1:0] accel_z_q;
  logic [`ACCEL_BITS-1:0] accel_y_q;
  logic [TEMP_BITS-1:0]   temp_q;
  accel_spi_pkg::sensor_status_flags_t status_q;

  wire refresh_due = (refresh_cnt_q == 14'(REFRESH_CYC - 1));
  wire refresh_now = refresh_due && cs_sync;

  accel_spi_sync2 #(
    .RESET_VAL (1'b1)
  ) u_cs_sync (
    .clk  (core_clk),
    .rst  (sys_rst),
    .en   (clk_en),
    .din  (chip_select_n),
    .dout (cs_sync)
  );

  // The timer restarts while selected so a full interval follows deselect.
  always_ff @(posedge core_clk) begin
    if (sys_rst || (clk_en && !cs_sync)) begin
      refresh_cnt_q <= 14'h0000;
    end else if (clk_en) begin
      refresh_cnt_q <= refresh_due ? 14'h0000 : refresh_cnt_q + 14'h0001;
    end
  end

  // Status is captured with the data words so a frame sees one snapshot.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      accel_z_q <= '0;
      accel_y_q <= '0;
      temp_q    <= '0;
      status_q  <= '0;
    end else if (clk_en && refresh_now) begin
      accel_z_q <= conv_accel_z;
      accel_y_q <= conv_accel_y;
      temp_q    <= conv_temp;
      status_q  <= chip_status;
    end
  end

  // ----------------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------------
  // Data registers are frozen while selected, so the link may read them
  // without a word crossing: they cannot change after the first two core cycles of a frame.
  accel_spi_pkg::link_state_t st_q;
  logic [3:0]  bit_cnt_q;
  logic [6:0]  cmd_sh_q;
  logic [10:0] tx_sh_q;
  logic        cmd_done;
  logic [7:0]  cmd_code;
  logic [10:0] tx_load;
  logic        cmd_known;
  logic        ev_tog_q;
  accel_spi_pkg::cmd_word_t ev_cmd_q;

  assign cmd_code = {cmd_sh_q, spi_mosi};
  assign cmd_done = (st_q == accel_spi_pkg::LINK_CMD) && (bit_cnt_q == 4'(`CMD_BITS - 1));

  wire is_measure_cmd   = (cmd_code == `CMD_MEASURE);
  wire is_temp   = (cmd_code == `CMD_TEMP_RW);
  wire is_stat   = (cmd_code == `CMD_STATUS_RD);
  wire is_reload = (cmd_code == `CMD_NV_RELOAD);
  wire is_stz    = (cmd_code == `CMD_SELFTEST_Z);
  wire is_sty    = (cmd_code == `CMD_SELFTEST_Y);
  wire is_rdz    = (cmd_code == `CMD_ACCEL_Z_RD);
  wire is_rdy    = (cmd_code == `CMD_ACCEL_Y_RD);

  assign cmd_known = is_measure_cmd | is_temp | is_stat | is_reload | is_stz | is_sty | is_rdz | is_rdy;

  // Read words are left-aligned so the first bit out is the top bit.
  wire [10:0] temp_word = {temp_q, {(11 - TEMP_BITS){1'b0}}};
  wire [10:0] stat_word = {status_q, 7'h00};
  assign tx_load = is_rdz  ? accel_z_q :
                   is_rdy  ? accel_y_q :
                   is_temp ? temp_word :
                   is_stat ? stat_word :
                             11'h000;

  // Chip select high acts as the frame's reset for the link state, bit counter, command shifter and output.
  // The frame state has no other reset, so the master must frame every transfer.
  always_ff @(posedge spi_sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      st_q      <= accel_spi_pkg::LINK_CMD;
      bit_cnt_q <= 4'h0;
      cmd_sh_q  <= 7'h00;
    end else begin
      cmd_sh_q  <= cmd_sh_q[5:0] == 6'h00 && bit_cnt_q == 4'h0 ? {6'h00, spi_mosi}
                                                               : {cmd_sh_q[5:0], spi_mosi};
      bit_cnt_q <= cmd_done ? 4'h0 : bit_cnt_q + 4'h1;
      if (cmd_done) begin
        st_q <= cmd_known ? accel_spi_pkg::LINK_DATA : accel_spi_pkg::LINK_IGNORE;
      end
    end
  end

  // Incoming data after a command is discarded, so writes do nothing.
  // The out word moves one place on each rising edge after the command,
  // ready for the falling edge that drives the next bit.
  always_ff @(posedge spi_sck) begin
    if (cmd_done) begin
      tx_sh_q <= tx_load;
    end else if (st_q == accel_spi_pkg::LINK_DATA) begin
      tx_sh_q <= {tx_sh_q[9:0], 1'b0};
    end
  end

  // Output changes on the falling edge; floating outside a known command.
  always_ff @(negedge spi_sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      spi_miso_o    <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else if (st_q == accel_spi_pkg::LINK_DATA) begin
      spi_miso_o    <= tx_sh_q[10];
      spi_miso_oe_n <= 1'b0;
    end else begin
      spi_miso_oe_n <= 1'b1;
    end
  end

  // Command event passes to the core domain by toggle. Only the system
  // reset clears it, never chip select, so a frame end cannot lose an event.
  always_ff @(posedge spi_sck or posedge sys_rst) begin
    if (sys_rst) begin
      ev_tog_q <= 1'b0;
      ev_cmd_q <= '0;
    end else if (cmd_done && cmd_known) begin
      ev_cmd_q <= '{valid: 1'b1, code: cmd_code};
      ev_tog_q <= ~ev_tog_q;
    end
  end

  // ----------------------------------------------------------------------
  // Mode control in the core domain
  // ----------------------------------------------------------------------
  // Only the toggle crosses; the code word settled long before the toggle
  // has passed both flip-flops, so it is read without a second sync.
  logic ev_sync;
  logic ev_seen_q;
  wire  ev_pulse = ev_sync ^ ev_seen_q;

  accel_spi_sync2 #(
    .RESET_VAL (1'b0)
  ) u_ev_sync (
    .clk  (core_clk),
    .rst  (sys_rst),
    .en   (clk_en),
    .din  (ev_tog_q),
    .dout (ev_sync)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ev_seen_q <= 1'b0;
    end else if (clk_en) begin
      ev_seen_q <= ev_sync;
    end
  end

  wire [7:0] ev_code   = ev_cmd_q.code;
  wire       ev_measure_cmd   = clk_en && ev_pulse && (ev_code == `CMD_MEASURE);
  wire       ev_stz    = clk_en && ev_pulse && (ev_code == `CMD_SELFTEST_Z);
  wire       ev_sty    = clk_en && ev_pulse && (ev_code == `CMD_SELFTEST_Y);
  wire       ev_reload = clk_en && ev_pulse && (ev_code == `CMD_NV_RELOAD);
  // Temperature reads decode to no mode change at all.

  // Each self-test channel holds until measure mode is commanded.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      selftest_z_en <= 1'b0;
    end else if (ev_measure_cmd) begin
      selftest_z_en <= 1'b0;
    end else if (ev_stz) begin
      selftest_z_en <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      selftest_y_en <= 1'b0;
    end else if (ev_measure_cmd) begin
      selftest_y_en <= 1'b0;
    end else if (ev_sty) begin
      selftest_y_en <= 1'b1;
    end
  end

  // The pump stays on while either channel is under test.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      charge_pump_en <= 1'b0;
    end else if (ev_measure_cmd) begin
      charge_pump_en <= 1'b0;
    end else if (ev_stz || ev_sty) begin
      charge_pump_en <= 1'b1;
    end
  end

  // The reload copies the stored word once per command.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_out_q <= '0;
    end else if (ev_reload) begin
      mem_out_q <= nv_data;
    end
  end

endmodule

// ----------------------------------------------------------------------
// Two-flop synchroniser
// ----------------------------------------------------------------------
// Only the second stage is read outside, so metastability stays inside.
// The reset value matches the idle level of the input, so no false edge
// follows reset.
module accel_spi_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clocking
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic en,
  // Data
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  logic sync_q;

  assign dout = sync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else if (en) begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

endmodule

// *** sim/accel_spi_decoder_props.sv ***
// Purpose: Checker for the serial command decoder.
// Assumes: Sees only the decoder's ports.
// Notes:   Link checks run on the serial clock, except the deselect float check on core_clk.
`include "accel_spi_consts.svh"
module accel_spi_decoder_props #(parameter int NV_BITS = 16) (
  // Core side
  input wire logic               core_clk,
  input wire logic               sys_rst,
  input wire logic               clk_en,
  input wire logic [NV_BITS-1:0] nv_data,
  input wire logic [NV_BITS-1:0] mem_out_q,
  input wire logic               charge_pump_en,
  input wire logic               selftest_z_en,
  input wire logic               selftest_y_en,
  // Link side
  input wire logic               spi_sck,
  input wire logic               chip_select_n,
  input wire logic               spi_mosi,
  input wire logic               spi_miso_oe_n
);
  // ----------
  // Properties
  // ----------
  logic [3:0] cnt_q;
  logic [7:0] code_q;
  // Deselect clears both, so a cut frame leaves no stale code behind.
  always_ff @(posedge spi_sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      cnt_q  <= 4'h0;
      code_q <= 8'h00;
    end else if (cnt_q < 4'h8) begin
      cnt_q  <= cnt_q + 4'h1;
      code_q <= {code_q[6:0], spi_mosi};
    end
  end
  wire known = code_q inside {`CMD_MEASURE, `CMD_TEMP_RW, `CMD_STATUS_RD, `CMD_NV_RELOAD,
    `CMD_SELFTEST_Z, `CMD_SELFTEST_Y, `CMD_ACCEL_Z_RD, `CMD_ACCEL_Y_RD};
  sequence s_desel;
    chip_select_n ##1 chip_select_n;
  endsequence
  a_pump_with_z: assert property (@(posedge core_clk) disable iff (sys_rst)
    selftest_z_en |-> charge_pump_en) else $error("pump off in Z test");
  a_pump_with_y: assert property (@(posedge core_clk) disable iff (sys_rst)
    selftest_y_en |-> charge_pump_en) else $error("pump off in Y test");
  a_reset_test_off: assert property (@(posedge core_clk)
    sys_rst && clk_en |=> !selftest_z_en && !selftest_y_en) else $error("test on");
  a_reset_mem_zero: assert property (@(posedge core_clk)
    sys_rst && clk_en |=> mem_out_q == '0) else $error("memory not cleared");
  a_mem_from_nv: assert property (@(posedge core_clk) disable iff (sys_rst)
    $changed(mem_out_q) |-> mem_out_q == nv_data || $past(sys_rst)) else $error("bad load");
  a_desel_float: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_desel |-> spi_miso_oe_n) else $error("output driven while deselected");
  a_cmd_quiet: assert property (@(posedge spi_sck) disable iff (chip_select_n)
    cnt_q < 4'h8 |-> spi_miso_oe_n) else $error("output driven during command");
  a_bad_cmd_float: assert property (@(posedge spi_sck) disable iff (chip_select_n)
    cnt_q == 4'h8 && !known |-> spi_miso_oe_n) else $error("output driven on bad code");
endmodule
bind accel_spi_command_decoder accel_spi_decoder_props #(.NV_BITS(NV_BITS)) u_props (
  .core_clk, .sys_rst, .clk_en, .nv_data, .mem_out_q, .charge_pump_en, .selftest_z_en,
  .selftest_y_en, .spi_sck, .chip_select_n, .spi_mosi, .spi_miso_oe_n);

// *** sim/spi_master_model.sv ***
// Purpose: Serial master standing in for the host controller.
// Assumes: Mode 0 framing, serial clock period 30 ns.
// Notes:   Clock rests low between frames; data keeps its last driven bit.
module spi_master_model (
  // Link pins
  output logic      spi_sck,
  output logic      chip_select_n,
  output logic      spi_mosi,
  input  wire logic spi_miso_o,
  input  wire logic spi_miso_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------
  // Frames
  // ------
  initial begin
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
    // Raised after time zero so the decoder sees a clean deselect edge.
    #1 chip_select_n = 1'b1;
  end
  // A floating line reads as the inverse of its last level, so stale bits never pass.
  task automatic xfer(input logic [7:0] cmd, input int n, output logic [10:0] rx,
                      output logic floated);
    logic lvl;
    rx = 11'h000;
    floated = 1'b1;
    lvl = 1'b0;
    chip_select_n = 1'b0;
    #157;
    for (int i = 0; i < 8 + n; i++) begin
      spi_mosi = (i < 8) ? cmd[7-i] : 1'b0;
      #15 spi_sck = 1'b1;
      if (i >= 8) begin
        lvl = spi_miso_oe_n ? ~lvl : spi_miso_o;
        rx = {rx[9:0], lvl};
        floated = floated & spi_miso_oe_n;
      end
      #15 spi_sck = 1'b0;
    end
    #15 chip_select_n = 1'b1;
  endtask
endmodule

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the serial command decoder.
// Assumes: Refresh period shortened to REFRESH core cycles.
// Notes:   Expected words are built from the stimulus values.
`include "accel_spi_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int REFRESH = 50;
  logic        core_clk, sys_rst, spi_sck, chip_select_n, spi_mosi, spi_miso_o;
  logic        spi_miso_oe_n, charge_pump_en, selftest_z_en, selftest_y_en, floated;
  logic [10:0] conv_accel_z, conv_accel_y, rx;
  logic [7:0]  conv_temp;
  logic [15:0] nv_data, mem_out_q;
  logic [7:0]  bad [3] = '{8'h55, 8'h0c, 8'hff};
  int          n_errors = 0, cmp_count = 0, cycles = 0;
  accel_spi_pkg::sensor_status_flags_t chip_status;
  wire  [2:0]  mode = {selftest_z_en, selftest_y_en, charge_pump_en};
  accel_spi_command_decoder #(.REFRESH_CYC(REFRESH)) u_accel_spi_command_decoder (
    .core_clk, .sys_rst, .clk_en(1'b1), .spi_sck, .chip_select_n, .spi_mosi, .spi_miso_o,
    .spi_miso_oe_n, .conv_accel_z, .conv_accel_y, .conv_temp, .chip_status, .nv_data,
    .charge_pump_en, .selftest_z_en, .selftest_y_en, .mem_out_q);
  spi_master_model u_spi_master_model (.spi_sck, .chip_select_n, .spi_mosi, .spi_miso_o,
    .spi_miso_oe_n);
  // -----
  // Tasks
  // -----
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic send(input logic [7:0] cmd, input int n);
    u_spi_master_model.xfer(cmd, n, rx, floated);
    repeat (6) @(posedge core_clk);
  endtask
  task automatic wait_fresh();
    repeat (2 * REFRESH) @(posedge core_clk);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    sys_rst = 1'b1;
    conv_accel_z = 11'h5a3;
    conv_accel_y = 11'h2c6;
    conv_temp = 8'h9c;
    chip_status = 4'h0;
    nv_data = 16'hc3a5;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    wait_fresh();
    check("mode", 16'(mode), 16'h0000);
    check("mem", mem_out_q, 16'h0000);
    send(`CMD_ACCEL_Z_RD, 11);
    check("accel z", 16'(rx), 16'h05a3);
    send(`CMD_ACCEL_Y_RD, 11);
    check("accel y", 16'(rx), 16'h02c6);
    send(`CMD_TEMP_RW, 11);
    check("temp", 16'(rx), 16'h04e0);
    conv_accel_z <= 11'h13c;
    send(`CMD_ACCEL_Z_RD, 11);
    check("held z", 16'(rx), 16'h05a3);
    for (int i = 0; i < 4; i++) begin
      chip_status <= 4'(1 << i);
      wait_fresh();
      send(`CMD_STATUS_RD, 11);
      check("status", 16'(rx), 16'(1 << (7 + i)));
    end
    send(`CMD_ACCEL_Z_RD, 11);
    check("new z", 16'(rx), 16'h013c);
    send(`CMD_SELFTEST_Z, 0);
    check("z test", 16'(mode), 16'h0005);
    send(`CMD_SELFTEST_Y, 0);
    check("y test", 16'(mode), 16'h0007);
    send(`CMD_TEMP_RW, 11);
    check("test kept", 16'(mode), 16'h0007);
    send(`CMD_MEASURE, 0);
    check("measure", 16'(mode), 16'h0000);
    send(`CMD_NV_RELOAD, 0);
    check("reload", mem_out_q, 16'hc3a5);
    nv_data <= 16'h1e7b;
    repeat (4) @(posedge core_clk);
    check("mem held", mem_out_q, 16'hc3a5);
    foreach (bad[k]) begin
      send(bad[k], 11);
      check("bad code", 16'(floated), 16'h0001);
    end
    test_done();
  end
endmodule
